// >>> rus_register_set.sv
// remote upgrade shift, update, control and status registers
`include "rus_defs.svh"

// What this block does
// RQ1 - fabric-reachable shift register writes update, samples update/status/control
// RQ2 - factory configuration in remote mode may write the update register
// RQ3 - no shift writes in local mode or application configurations
// RQ4 - read in application configuration copies control into shift register
// RQ5 - fabric-triggered reconfiguration start in remote mode moves update register into control register
// RQ6 - update register loaded only from shift register by factory update
// RQ7 - read in factory configuration copies update into shift register
// RQ8 - every reconfiguration records its cause in the status register
// RQ9 - capture cycle loads status into the shift register
// RQ10 - control and status run on the internal oscillator clock
// RQ11 - shift and update registers advance on the user shift clock
// RQ12 - remote mode: page select powers up all zeros
// RQ13 - local mode: page select powers up as one
// RQ14 - control not writable in local mode, writable by remote factory
// RQ15 - control word: flag, low page, high page, watchdog enable, time-out
// RQ16 - flag high at local power-up, cleared on error fall-back
// RQ17 - flag high: control register read only
// RQ18 - flag low: writes allowed, watchdog kept disabled
// RQ19 - factory logic sets flag when writing an application page
// RQ20 - low page defaults 001 local, 000 remote; serial address 18:16
// RQ21 - high page defaults zero; serial address 22:19
// RQ22 - time-out field is top twelve of 29-bit count, 17 zeros below
// RQ23 - remote mode: watchdog enable and time-out default zero
// RQ24 - five status bits: crc, error, fabric, external reset, watchdog
// RQ25 - fabric trigger in remote mode copies update into control and reconfigures
// RQ26 - shift register moves one bit per user shift clock rise
module rus_register_set
   import rus_pkg::*;
(
   // oscillator clock and reset
   input wire logic clk,
   input wire logic rst,
   // mode strap: high selects remote update, low local update
   input wire logic remote_mode,
   // fabric shift interface
   input wire logic upgrade_shift_clock,
   input wire logic shift_data_in,
   input wire logic shift_enable,
   input wire logic capture_req,
   input wire logic read_req,
   input wire logic update_req,
   input wire logic fabric_reconfig_trigger_n,
   // reconfiguration causes from the configuration logic
   input wire logic config_error_status_n,
   input wire logic ext_config_reset_n,
   input wire logic crc_error,
   input wire logic wdog_expired,
   // register views and control outputs
   output logic shift_data_out,
   output rus_word_t upgrade_control_word,
   output rus_status_t status_word,
   output logic [6:0] page_select,
   output logic wdog_enable,
   output logic [`RUS_WDOG_CNT_W-1:0] wdog_count_load,
   output logic write_access,
   output logic reconfig_start
);
   // synchronised pins
   localparam logic [11:0] SYNC_RST = 12'h01c; // low-active pins idle high
   logic [11:0] pins_raw;
   logic [11:0] pins_s;
   logic sclk_s, sdin_s, sen_s, cap_s, rd_s, upd_s, trig_n_s;
   logic errst_n_s, extrst_n_s, crc_s, wdx_s, remote_s;

   assign pins_raw = {remote_mode, upgrade_shift_clock, shift_data_in,
                      shift_enable, capture_req, read_req, update_req,
                      fabric_reconfig_trigger_n, config_error_status_n,
                      ext_config_reset_n, crc_error, wdog_expired};

   rus_sync #(.W(12), .RST_VAL(SYNC_RST)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign remote_s = pins_s[11];
   assign sclk_s = pins_s[10];
   assign sdin_s = pins_s[9];
   assign sen_s = pins_s[8];
   assign cap_s = pins_s[7];
   assign rd_s = pins_s[6];
   assign upd_s = pins_s[5];
   assign trig_n_s = pins_s[4];
   assign errst_n_s = pins_s[3];
   assign extrst_n_s = pins_s[2];
   assign crc_s = pins_s[1];
   assign wdx_s = pins_s[0];

   // state
   rus_state_e state_reg, state_next;
   logic [2:0] init_cnt_reg, init_cnt_next;
   logic remote_reg, remote_next;
   logic [5:0] prev_reg, prev_next;
   rus_word_t shift_reg, shift_next;
   rus_word_t update_reg, update_next;
   rus_word_t ctrl_reg, ctrl_next;
   rus_status_t status_reg, status_next;
   logic recfg_reg, recfg_next;
   logic wen_reg, wen_next;
   logic wdog_en_reg, wdog_en_next;
   logic [`RUS_WDOG_CNT_W-1:0] wdog_cnt_reg, wdog_cnt_next;
   logic [6:0] page_reg, page_next;

   // event decode
   logic running;
   logic sclk_rise;
   logic wr_ok;
   rus_cause_e cause;

   assign running = (state_reg == RUS_RUN);
   assign sclk_rise = running && sclk_s && !prev_reg[0]; // RQ11
   // write access only for a factory image in remote mode
   assign wr_ok = remote_reg && !ctrl_reg[`RUS_ANF_BIT]; // RQ2 RQ3 RQ14 RQ17

   // cause priority: external reset, error pin, crc, watchdog, fabric
   always_comb begin
      cause = RUS_CAUSE_NONE;
      if (!running) begin
         cause = RUS_CAUSE_NONE;
      end else if (!extrst_n_s && prev_reg[3]) begin
         cause = RUS_CAUSE_EXTRST;
      end else if (!errst_n_s && prev_reg[4]) begin
         cause = RUS_CAUSE_ERRSTAT;
      end else if (crc_s && !prev_reg[2]) begin
         cause = RUS_CAUSE_CRC;
      end else if (wdx_s && !prev_reg[1] && wdog_en_reg) begin // RQ18
         cause = RUS_CAUSE_WDOG;
      end else if (trig_n_s && !prev_reg[5]) begin
         cause = RUS_CAUSE_CORE;
      end
   end

   // next values of every register
   always_comb begin
      state_next = state_reg;
      init_cnt_next = init_cnt_reg;
      remote_next = remote_reg;
      prev_next = {trig_n_s, errst_n_s, extrst_n_s, crc_s, wdx_s, sclk_s};
      shift_next = shift_reg;
      update_next = update_reg;
      ctrl_next = ctrl_reg;
      status_next = status_reg;
      recfg_next = 1'b0;
      case (state_reg)
         RUS_INIT: begin
            // wait for synchronisers, then catch the mode strap
            init_cnt_next = init_cnt_reg + 3'h1;
            if (init_cnt_reg == `RUS_INIT_CYCLES) begin
               state_next = RUS_RUN;
               remote_next = remote_s;
               if (remote_s) begin
                  ctrl_next = `RUS_CTRL_REMOTE_RST; // RQ12 RQ20 RQ21 RQ23
               end else begin
                  ctrl_next = `RUS_CTRL_LOCAL_RST; // RQ13 RQ16 RQ20
               end
            end
         end
         RUS_RUN: begin
            // user-clock side: shift, capture, read, update
            if (sclk_rise) begin
               if (sen_s) begin
                  shift_next = {sdin_s, shift_reg[20:1]}; // RQ26 RQ1
               end else if (cap_s) begin
                  shift_next = rus_word_t'(status_reg); // RQ9
               end else if (rd_s) begin
                  if (ctrl_reg[`RUS_ANF_BIT]) begin
                     shift_next = ctrl_reg; // RQ4
                  end else begin
                     shift_next = update_reg; // RQ7
                  end
               end else if (upd_s && wr_ok) begin
                  update_next = shift_reg; // RQ6 RQ2
               end
            end
            // oscillator side: reconfiguration
            if (cause != RUS_CAUSE_NONE) begin
               recfg_next = 1'b1;
               status_next = `RUS_STAT_RST;
               ctrl_next = `RUS_CTRL_REMOTE_RST; // RQ16
               case (cause)
                  RUS_CAUSE_EXTRST: begin
                     status_next[`RUS_ST_EXTRST] = 1'b1; // RQ8 RQ24
                     if (!remote_reg) begin
                        ctrl_next = `RUS_CTRL_LOCAL_RST;
                     end
                  end
                  RUS_CAUSE_ERRSTAT: begin
                     status_next[`RUS_ST_ERRSTAT] = 1'b1; // RQ8
                  end
                  RUS_CAUSE_CRC: begin
                     status_next[`RUS_ST_CRC] = 1'b1; // RQ8
                  end
                  RUS_CAUSE_WDOG: begin
                     status_next[`RUS_ST_WDOG] = 1'b1; // RQ8
                  end
                  RUS_CAUSE_CORE: begin
                     status_next[`RUS_ST_CORE] = 1'b1; // RQ8
                     if (remote_reg) begin
                        ctrl_next = update_reg; // RQ5 RQ25 RQ19
                     end else begin
                        ctrl_next = `RUS_CTRL_LOCAL_RST;
                     end
                  end
                  default: status_next = status_reg;
               endcase
            end
         end
         default: state_next = RUS_INIT;
      endcase
      // output views follow the control word
      wen_next = (state_next == RUS_RUN) && remote_next &&
                 !ctrl_next[`RUS_ANF_BIT]; // RQ3 RQ14
      wdog_en_next = ctrl_next[`RUS_ANF_BIT] &&
                     ctrl_next[`RUS_WDEN_BIT]; // RQ18
      wdog_cnt_next = {ctrl_next[`RUS_WDTO_MSB:`RUS_WDTO_LSB],
                       {`RUS_WDOG_LOW_ZEROS{1'b0}}}; // RQ22
      page_next = ctrl_next[`RUS_PAGE_HI_MSB:`RUS_PAGE_LO_LSB]; // RQ15
   end

   // register stage, control and status on the oscillator clock
   always_ff @(posedge clk or posedge rst) begin // RQ10
      if (rst) begin
         state_reg <= RUS_INIT;
         init_cnt_reg <= 3'h0;
         remote_reg <= 1'b1;
         prev_reg <= 6'h38; // edge detectors at idle levels
         shift_reg <= 21'h000000;
         update_reg <= 21'h000000;
         ctrl_reg <= `RUS_CTRL_REMOTE_RST;
         status_reg <= `RUS_STAT_RST;
         recfg_reg <= 1'b0;
         wen_reg <= 1'b0;
         wdog_en_reg <= 1'b0;
         wdog_cnt_reg <= 29'h00000000;
         page_reg <= 7'h00;
      end else begin
         state_reg <= state_next;
         init_cnt_reg <= init_cnt_next;
         remote_reg <= remote_next;
         prev_reg <= prev_next;
         shift_reg <= shift_next;
         update_reg <= update_next;
         ctrl_reg <= ctrl_next;
         status_reg <= status_next;
         recfg_reg <= recfg_next;
         wen_reg <= wen_next;
         wdog_en_reg <= wdog_en_next;
         wdog_cnt_reg <= wdog_cnt_next;
         page_reg <= page_next;
      end
   end

   // outputs straight from flip-flops
   assign shift_data_out = shift_reg[0];
   assign upgrade_control_word = ctrl_reg;
   assign status_word = status_reg;
   assign page_select = page_reg; // RQ20 RQ21
   assign wdog_enable = wdog_en_reg;
   assign wdog_count_load = wdog_cnt_reg;
   assign write_access = wen_reg;
   assign reconfig_start = recfg_reg;

   // checks
   property p_no_write_blocked;
      @(posedge clk) disable iff (rst)
      !wr_ok |=> update_reg == $past(update_reg);
   endproperty
   a_no_write_blocked: assert property (p_no_write_blocked) // RQ3
      else $error("update register changed without write access");

   property p_update_load;
      @(posedge clk) disable iff (rst)
      (sclk_rise && !sen_s && !cap_s && !rd_s && upd_s && wr_ok &&
       cause != RUS_CAUSE_CORE) |=> update_reg == $past(shift_reg);
   endproperty
   a_update_load: assert property (p_update_load) // RQ6
      else $error("update operation did not load shift contents");

   property p_read_app;
      @(posedge clk) disable iff (rst)
      (sclk_rise && !sen_s && !cap_s && rd_s && ctrl_reg[0])
      |=> shift_reg == $past(ctrl_reg);
   endproperty
   a_read_app: assert property (p_read_app) // RQ4
      else $error("application read did not return control word");

   property p_read_factory;
      @(posedge clk) disable iff (rst)
      (sclk_rise && !sen_s && !cap_s && rd_s && !ctrl_reg[0])
      |=> shift_reg == $past(update_reg);
   endproperty
   a_read_factory: assert property (p_read_factory) // RQ7
      else $error("factory read did not return update word");

   property p_capture;
      @(posedge clk) disable iff (rst)
      (sclk_rise && !sen_s && cap_s)
      |=> shift_reg == rus_word_t'($past(status_reg));
   endproperty
   a_capture: assert property (p_capture) // RQ9
      else $error("capture did not load status");

   property p_shift;
      @(posedge clk) disable iff (rst)
      (sclk_rise && sen_s) |=> (shift_reg[19:0] == $past(shift_reg[20:1]))
         && (shift_reg[20] == $past(sdin_s));
   endproperty
   a_shift: assert property (p_shift) // RQ26
      else $error("shift register did not advance one bit");

   property p_core_remote;
      @(posedge clk) disable iff (rst)
      (cause == RUS_CAUSE_CORE && remote_reg)
      |=> ctrl_reg == $past(update_reg) && reconfig_start ##1 !reconfig_start;
   endproperty
   a_core_remote: assert property (p_core_remote) // RQ25
      else $error("fabric trigger did not load control from update");

   property p_status_cause;
      @(posedge clk) disable iff (rst)
      reconfig_start |-> $onehot(status_reg);
   endproperty
   a_status_cause: assert property (p_status_cause) // RQ8
      else $error("reconfiguration without single cause bit");

   property p_fallback;
      @(posedge clk) disable iff (rst)
      (cause == RUS_CAUSE_CRC || cause == RUS_CAUSE_ERRSTAT ||
       cause == RUS_CAUSE_WDOG) |=> ctrl_reg == 21'h000000 ##1 !wdog_enable;
   endproperty
   a_fallback: assert property (p_fallback) // RQ16
      else $error("error fall-back did not clear control word");

   property p_wdog_off;
      @(posedge clk) disable iff (rst)
      !ctrl_reg[0] |-> !wdog_enable;
   endproperty
   a_wdog_off: assert property (p_wdog_off) // RQ18
      else $error("watchdog enabled in factory configuration");

   property p_wdog_count;
      @(posedge clk) disable iff (rst)
      wdog_count_load == {ctrl_reg[20:9], 17'h00000};
   endproperty
   a_wdog_count: assert property (p_wdog_count) // RQ22
      else $error("watchdog count not aligned to time-out field");

   property p_powerup;
      @(posedge clk) disable iff (rst)
      $rose(running) |-> (remote_reg ? ctrl_reg == 21'h000000 :
                          (page_select == 7'h01 && ctrl_reg[0]));
   endproperty
   a_powerup: assert property (p_powerup) // RQ12 RQ13
      else $error("wrong control word at power-up");

   c_update: cover property (@(posedge clk) disable iff (rst)
      sclk_rise && upd_s && wr_ok);
   c_core: cover property (@(posedge clk) disable iff (rst)
      cause == RUS_CAUSE_CORE);
   c_capture: cover property (@(posedge clk) disable iff (rst)
      sclk_rise && cap_s && !sen_s);
endmodule // rus_register_set

// >>> rus_defs.svh
// field positions, reset values and timing counts of the upgrade register set
`ifndef RUS_DEFS_SVH
`define RUS_DEFS_SVH

// control word layout
`define RUS_CTRL_W 21
`define RUS_ANF_BIT 0
`define RUS_PAGE_LO_MSB 3
`define RUS_PAGE_LO_LSB 1
`define RUS_PAGE_HI_MSB 7
`define RUS_PAGE_HI_LSB 4
`define RUS_WDEN_BIT 8
`define RUS_WDTO_MSB 20
`define RUS_WDTO_LSB 9
`define RUS_WDOG_LOW_ZEROS 17
`define RUS_WDOG_CNT_W 29

// status word layout
`define RUS_STAT_W 5
`define RUS_ST_CRC 0
`define RUS_ST_ERRSTAT 1
`define RUS_ST_CORE 2
`define RUS_ST_EXTRST 3
`define RUS_ST_WDOG 4

// reset and fall-back values
`define RUS_CTRL_REMOTE_RST 21'h000000
`define RUS_CTRL_LOCAL_RST 21'h000003
`define RUS_STAT_RST 5'h00

// timing: synchroniser depth and start-up settle cycles
`define RUS_SYNC_STAGES 2
`define RUS_INIT_CYCLES 3'h3

`endif

// >>> rus_pkg.sv
// types shared by the upgrade register set
package rus_pkg;
   typedef enum logic [0:0] {
      RUS_INIT = 1'b0,
      RUS_RUN = 1'b1
   } rus_state_e;

   typedef enum logic [2:0] {
      RUS_CAUSE_NONE = 3'b000,
      RUS_CAUSE_EXTRST = 3'b001,
      RUS_CAUSE_ERRSTAT = 3'b010,
      RUS_CAUSE_CRC = 3'b011,
      RUS_CAUSE_WDOG = 3'b100,
      RUS_CAUSE_CORE = 3'b101
   } rus_cause_e;

   typedef logic [20:0] rus_word_t;
   typedef logic [4:0] rus_status_t;
endpackage

// >>> rus_sync.sv
// two flip-flop synchroniser, one per input bit
module rus_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous inputs and their synchronised copies
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] stable_reg;

   // per-bit two-stage capture
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_reg[i] <= RST_VAL[i];
               stable_reg[i] <= RST_VAL[i];
            end else begin
               meta_reg[i] <= async_in[i];
               stable_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign sync_out = stable_reg;
endmodule // rus_sync

// >>> rus_fabric_model.sv
// fabric user logic model driving the upgrade shift interface
module rus_fabric_model
   import rus_pkg::*;
(
   // oscillator clock
   input wire logic clk,
   // shift interface toward the register set
   output logic upgrade_shift_clock,
   output logic shift_data_in,
   output logic shift_enable,
   output logic capture_req,
   output logic read_req,
   output logic update_req,
   input wire logic shift_data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int HALF = 20; // 80 ns half period, 160 ns user clock

   // quiet interface at time zero, user clock parked low
   initial begin
      upgrade_shift_clock = 1'b0;
      shift_data_in = 1'b0;
      {shift_enable, capture_req, read_req, update_req} = 4'h0;
   end

   // one user clock period with one action; bit seen just before the rise
   task automatic step(input logic [3:0] act, input logic din,
                       output logic dout);
      @(posedge clk);
      upgrade_shift_clock <= 1'b0;
      {shift_enable, capture_req, read_req, update_req} <= act;
      shift_data_in <= din;
      repeat (HALF) @(posedge clk);
      dout = shift_data_out;
      upgrade_shift_clock <= 1'b1;
      repeat (HALF - 1) @(posedge clk);
   endtask

   // end of frame: clock stands low, data line shows no stale value
   task automatic idle();
      @(posedge clk);
      upgrade_shift_clock <= 1'b0;
      {shift_enable, capture_req, read_req, update_req} <= 4'h0;
      shift_data_in <= ~shift_data_in;
      repeat (HALF) @(posedge clk);
   endtask

   // optional load action, 21 shifts bit 0 first, optional update after
   task automatic word(input logic [3:0] pre, input rus_word_t wr,
                       input logic [3:0] post, output rus_word_t rd);
      logic b;
      if (pre != 4'h0) step(pre, 1'b0, b);
      for (int i = 0; i < 21; i++) begin
         step(4'h8, wr[i], b);
         rd[i] = b;
      end
      if (post != 4'h0) step(post, 1'b0, b);
      idle();
   endtask
endmodule // rus_fabric_model

// >>> tb_remote_upgrade_register_set.sv
// self-checking bench for the remote upgrade register set
module tb_remote_upgrade_register_set
   import rus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst, remote_mode, upgrade_shift_clock, shift_data_in;
   logic shift_enable, capture_req, read_req, update_req, shift_data_out;
   logic fabric_reconfig_trigger_n, config_error_status_n;
   logic ext_config_reset_n, crc_error, wdog_expired;
   rus_word_t upgrade_control_word;
   rus_status_t status_word;
   logic [6:0] page_select;
   logic wdog_enable, write_access, reconfig_start;
   logic [28:0] wdog_count_load;
   logic [4:0] ev;
   int mismatches = 0;
   int n_checks = 0;
   int n_starts = 0;

   // cause pins, indexed by their status bit
   assign crc_error = ev[0];
   assign config_error_status_n = ~ev[1];
   assign fabric_reconfig_trigger_n = ~ev[2];
   assign ext_config_reset_n = ~ev[3];
   assign wdog_expired = ev[4];

   rus_register_set dut (
      .clk(clk), .rst(rst), .remote_mode(remote_mode),
      .upgrade_shift_clock(upgrade_shift_clock),
      .shift_data_in(shift_data_in), .shift_enable(shift_enable),
      .capture_req(capture_req), .read_req(read_req),
      .update_req(update_req),
      .fabric_reconfig_trigger_n(fabric_reconfig_trigger_n),
      .config_error_status_n(config_error_status_n),
      .ext_config_reset_n(ext_config_reset_n), .crc_error(crc_error),
      .wdog_expired(wdog_expired), .shift_data_out(shift_data_out),
      .upgrade_control_word(upgrade_control_word),
      .status_word(status_word), .page_select(page_select),
      .wdog_enable(wdog_enable), .wdog_count_load(wdog_count_load),
      .write_access(write_access), .reconfig_start(reconfig_start));

   rus_fabric_model fab (
      .clk(clk), .upgrade_shift_clock(upgrade_shift_clock),
      .shift_data_in(shift_data_in), .shift_enable(shift_enable),
      .capture_req(capture_req), .read_req(read_req),
      .update_req(update_req), .shift_data_out(shift_data_out));

   // 250 MHz oscillator clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // count reconfiguration pulses where outputs are settled
   always @(negedge clk) begin
      if (reconfig_start === 1'b1) n_starts++;
   end

   task automatic chk(input string what, input logic [28:0] seen,
                      input logic [28:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // reset with the mode strap, then settle past start-up
   task automatic do_reset(input logic mode);
      @(posedge clk);
      rst <= 1'b1;
      remote_mode <= mode;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   // every view derived from one expected control word
   task automatic views(input rus_word_t cw);
      chk("control_word", 29'(upgrade_control_word), 29'(cw));
      chk("page_select", 29'(page_select), 29'(cw[7:1]));
      chk("wdog_enable", 29'(wdog_enable), 29'(cw[0] & cw[8]));
      chk("wdog_count_load", wdog_count_load, {cw[20:9], 17'h0});
      chk("write_access", 29'(write_access),
          29'(remote_mode & ~cw[0]));
   endtask

   // pulse one cause pin and count the reconfigurations it starts
   task automatic fire(input int k, input int exp_n, input rus_status_t st,
                       input rus_word_t cw);
      int n0;
      n0 = n_starts;
      @(posedge clk);
      ev[k] <= 1'b1;
      repeat (8) @(posedge clk);
      ev[k] <= 1'b0;
      repeat (10) @(posedge clk);
      chk("reconfig_count", 29'(n_starts - n0), 29'(exp_n));
      chk("status_word", 29'(status_word), 29'(st));
      views(cw);
   endtask

   // main sequence: remote mode first, then local mode
   initial begin : main
      rus_word_t w;
      rus_word_t r;
      rst = 1'b1;
      remote_mode = 1'b1;
      ev = 5'h00;
      do_reset(1'b1);
      views(21'h000000);
      chk("status_word", 29'(status_word), 29'h0);
      w = {12'habc, 1'b1, 4'h5, 3'h6, 1'b1};
      fab.word(4'h0, w, 4'h1, r);
      fab.word(4'h2, ~w, 4'h0, r);
      chk("update_readback", 29'(r), 29'(w));
      views(21'h000000);
      fire(2, 1, 5'h04, w);
      fab.word(4'h2, 21'h000000, 4'h1, r);
      chk("control_readback", 29'(r), 29'(w));
      fab.word(4'h4, 21'h000000, 4'h0, r);
      chk("status_capture", 29'(r[4:0]), 29'h04);
      fire(2, 1, 5'h04, w);
      fire(4, 1, 5'h10, 21'h000000);
      fire(4, 0, 5'h10, 21'h000000);
      fire(0, 1, 5'h01, 21'h000000);
      fire(1, 1, 5'h02, 21'h000000);
      fire(3, 1, 5'h08, 21'h000000);
      do_reset(1'b0);
      views(21'h000003);
      chk("status_word", 29'(status_word), 29'h0);
      fab.word(4'h2, 21'h000000, 4'h0, r);
      chk("local_control_readback", 29'(r), 29'h3);
      fire(0, 1, 5'h01, 21'h000000);
      fab.word(4'h0, w, 4'h1, r);
      fab.word(4'h2, 21'h000000, 4'h0, r);
      chk("local_update_blocked", 29'(r), 29'h0);
      fire(2, 1, 5'h04, 21'h000003);
      fire(1, 1, 5'h02, 21'h000000);
      fire(3, 1, 5'h08, 21'h000003);
      give_verdict();
   end

   // hang guard, well beyond the expected run length
   initial begin : watchdog
      repeat (40000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule // tb_remote_upgrade_register_set
